// File: logic/cfdu_config_ctrl.v
/*
 Configuration loader: nonvolatile store, double-buffered latches, update
 options, state fetch and a byte-level serial slave view.
 Assumes the serial bus is framed into byte strobes by a bit-level front
 end on mclk; only pins and the link clock cross domains here.
*/
`timescale 1ns/100ps
`include "cfdu_defines.vh"
module cfdu_config_ctrl #(
    parameter STATE_DELAY_CYC = `CFDU_STATE_DELAY_CYC,
    parameter ERASE_CYC       = `CFDU_ERASE_CYC,
    parameter FETCH_CYC       = `CFDU_FETCH_CYC,
    parameter [7:0] MAKER_ID  = 8'hA5, // Arbitrary value.
    parameter [7:0] REVISION  = 8'h01, // Arbitrary value.
    parameter [7:0] BRAND0    = 8'h5A, // Arbitrary value.
    parameter [7:0] BRAND1    = 8'h3C  // Arbitrary value.
) (
    // Clock, reset, enable.
    input  wire        mclk,
    input  wire        reset_n,
    input  wire        clkEn,
    // Supply lockout and address pins (asynchronous levels).
    input  wire        supplyAboveLockout,
    input  wire        addressPinHigh,
    input  wire        addressPinLow,
    // Link clock, sampled for edges only.
    input  wire        linkClk,
    // Byte-level serial slave front end.
    input  wire        busStart,
    input  wire [6:0]  busAddr,
    input  wire        busRead,
    input  wire        busByteValid,
    input  wire [7:0]  busByte,
    input  wire        busStop,
    output wire        busAck,
    output reg  [7:0]  busRdData,
    // Sequencing engine side.
    input  wire        stateCondMet,
    output reg  [63:0] stateWord,
    output reg  [5:0]  stateIndex,
    output wire        stateBusy,
    // Status.
    output wire        downloadDone,
    output reg  [6:0]  slaveAddr,
    output wire        linkEdge
);
    ////////////////////////////////////////////////////////////////////////
    wire lockSync;
    wire pinHiSync;
    wire pinLoSync;
    wire linkLowSync;
    cfdu_sync2 uSyncLock (
        .mclk    (mclk),
        .reset_n (reset_n),
        .clkEn   (clkEn),
        .asyncIn (supplyAboveLockout),
        .syncOut (lockSync)
    );
    cfdu_sync2 uSyncHi (
        .mclk    (mclk),
        .reset_n (reset_n),
        .clkEn   (clkEn),
        .asyncIn (addressPinHigh),
        .syncOut (pinHiSync)
    );
    cfdu_sync2 uSyncLo (
        .mclk    (mclk),
        .reset_n (reset_n),
        .clkEn   (clkEn),
        .asyncIn (addressPinLow),
        .syncOut (pinLoSync)
    );
    // The link idles high, so its low level is tracked: reset then shows no false edge.
    cfdu_sync2 uSyncLink (
        .mclk    (mclk),
        .reset_n (reset_n),
        .clkEn   (clkEn),
        .asyncIn (~linkClk),
        .syncOut (linkLowSync)
    );
    reg linkWasLow_q;
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            linkWasLow_q <= 1'b0;
        end else if (clkEn) begin
            linkWasLow_q <= linkLowSync;
        end
    end
    assign linkEdge = ~linkLowSync & linkWasLow_q;

    ////////////////////////////////////////////////////////////////////////
    // Storage is flip-flops: 1 KiB nonvolatile, two latch stages of RAM.
    reg [7:0] nvMem [0:1023];
    reg [7:0] latchA [0:`CFDU_CFG_BYTES-1];
    reg [7:0] latchB [0:`CFDU_CFG_BYTES-1];
    reg [7:0] updCtl_q;
    reg [7:0] dnCtl_q;
    reg [7:0] ptr_q;
    reg [7:0] ptrLo_q;
    reg       ptrNv_q;
    reg [1:0] byteCnt_q;
    reg       selected_q;
    reg [7:0] loByte_q;

    localparam ST_WAIT  = 3'h0;
    localparam ST_COPYA = 3'h1;
    localparam ST_XFER  = 3'h2;
    localparam ST_DELAY = 3'h3;
    localparam ST_RUN   = 3'h4;
    localparam ST_ERASE = 3'h5;
    localparam ST_FETCH = 3'h6;
    reg [2:0]  state_q;
    reg [7:0]  copyIdx_q;
    reg        ready_q;
    reg [23:0] timer_q;
    reg [4:0]  eraseIdx_q;
    reg [4:0]  erasePage_q;
    reg [5:0]  nextIdx_q;

    wire busy = (state_q != ST_RUN);
    assign downloadDone = ready_q;
    assign stateBusy    = (state_q == ST_FETCH) | (state_q == ST_DELAY);
    // No answer at all until ready, nor while erasing or loading pages.
    // Pending one-cycle actions also refuse, so no acknowledged byte is lost.
    wire runPending = updCtl_q[`CFDU_BIT_XFER] | dnCtl_q[`CFDU_BIT_DOWNLOAD] |
                      stateCondMet;
    assign busAck = selected_q & ~busy & ~runPending;

    wire [9:0] nvAddr   = {ptr_q[1:0], ptrLo_q};
    wire [9:0] stateNvA = 10'h200 + {1'b0, nextIdx_q, 3'h0};

    ////////////////////////////////////////////////////////////////////////
    // Read mux.
    always @* begin
        busRdData = 8'h00;
        if (ptrNv_q) begin
            busRdData = nvMem[nvAddr];
        end else if (ptr_q == `CFDU_ADDR_UPDATE) begin
            busRdData = updCtl_q;
        end else if (ptr_q == `CFDU_ADDR_DOWNLOAD) begin
            busRdData = dnCtl_q;
        end else if (ptr_q == `CFDU_ADDR_MAKER) begin
            busRdData = MAKER_ID;
        end else if (ptr_q == `CFDU_ADDR_REVISION) begin
            busRdData = REVISION;
        end else if (ptr_q == `CFDU_ADDR_BRAND0) begin
            busRdData = BRAND0;
        end else if (ptr_q == `CFDU_ADDR_BRAND1) begin
            busRdData = BRAND1;
        end else if (ptr_q <= `CFDU_RAM_TOP) begin
            busRdData = latchA[ptr_q];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    integer i;
    wire wrByte = busByteValid & selected_q & ~busRead & ~busy;
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_q     <= ST_WAIT;
            copyIdx_q   <= 8'h00;
            ready_q     <= 1'b0;
            timer_q     <= 24'h000000;
            updCtl_q    <= 8'h00;
            dnCtl_q     <= 8'h00;
            ptr_q       <= 8'h00;
            ptrLo_q     <= 8'h00;
            ptrNv_q     <= 1'b0;
            byteCnt_q   <= 2'h0;
            selected_q  <= 1'b0;
            loByte_q    <= 8'h00;
            eraseIdx_q  <= 5'h00;
            erasePage_q <= 5'h00;
            nextIdx_q   <= 6'h00;
            stateIndex  <= 6'h00;
            stateWord   <= 64'h0;
            slaveAddr   <= 7'h00;
        end else if (clkEn) begin
            slaveAddr <= {`CFDU_SLAVE_UPPER, pinHiSync, pinLoSync};
            // Single-action bits read back zero after one cycle.
            updCtl_q[`CFDU_BIT_XFER]    <= 1'b0;
            dnCtl_q[`CFDU_BIT_DOWNLOAD] <= 1'b0;
            if (busStart) begin
                selected_q <= (busAddr == slaveAddr);
                byteCnt_q  <= 2'h0;
            end
            if (busStop) begin
                selected_q <= 1'b0;
            end
            case (state_q)
                ST_WAIT: begin
                    if (lockSync) begin
                        state_q   <= ST_COPYA;
                        copyIdx_q <= 8'h00;
                    end
                end
                ST_COPYA: begin
                    // Pages 0-6 fill the first stage only, one byte a cycle.
                    latchA[copyIdx_q] <= nvMem[{2'h0, copyIdx_q}];
                    if (copyIdx_q == `CFDU_CFG_BYTES - 1) begin
                        state_q <= ST_XFER;
                    end else begin
                        copyIdx_q <= copyIdx_q + 8'h01;
                    end
                end
                ST_XFER: begin
                    for (i = 0; i < `CFDU_CFG_BYTES; i = i + 1) begin
                        latchB[i] <= latchA[i];
                    end
                    if (ready_q) begin
                        state_q <= ST_RUN;
                    end else begin
                        state_q <= ST_DELAY;
                        timer_q <= 24'h000000;
                    end
                end
                ST_DELAY: begin
                    // The first state waits a fixed time after download.
                    if (timer_q == STATE_DELAY_CYC - 1) begin
                        for (i = 0; i < 8; i = i + 1) begin
                            stateWord[i*8 +: 8] <= nvMem[10'h200 + i];
                        end
                        stateIndex <= 6'h00;
                        ready_q    <= 1'b1;
                        state_q    <= ST_RUN;
                    end else begin
                        timer_q <= timer_q + 24'h000001;
                    end
                end
                ST_FETCH: begin
                    if (timer_q == FETCH_CYC - 1) begin
                        for (i = 0; i < 8; i = i + 1) begin
                            stateWord[i*8 +: 8] <= nvMem[stateNvA + i];
                        end
                        stateIndex <= nextIdx_q;
                        state_q    <= ST_RUN;
                    end else begin
                        timer_q <= timer_q + 24'h000001;
                    end
                end
                ST_ERASE: begin
                    // One byte of the page to ones per cycle, then hold busy.
                    nvMem[{erasePage_q, eraseIdx_q}] <= 8'hFF;
                    if (eraseIdx_q != 5'h1F) begin
                        eraseIdx_q <= eraseIdx_q + 5'h01;
                    end
                    if (timer_q == ERASE_CYC - 1) begin
                        state_q <= ST_RUN;
                    end else begin
                        timer_q <= timer_q + 24'h000001;
                    end
                end
                ST_RUN: begin
                    if (updCtl_q[`CFDU_BIT_XFER]) begin
                        state_q <= ST_XFER;
                    end else if (dnCtl_q[`CFDU_BIT_DOWNLOAD]) begin
                        state_q   <= ST_COPYA;
                        copyIdx_q <= 8'h00;
                    end else if (stateCondMet) begin
                        // Slot 63 is reserved; the index wraps to slot 0.
                        nextIdx_q <= (stateIndex == 6'h3E) ? 6'h00 :
                                     stateIndex + 6'h01;
                        timer_q   <= 24'h000000;
                        state_q   <= ST_FETCH;
                    end else if (wrByte) begin
                        byteCnt_q <= (byteCnt_q == 2'h3) ? 2'h3 : byteCnt_q + 2'h1;
                        if (byteCnt_q == 2'h0) begin
                            if (busByte == `CFDU_CMD_ERASE) begin
                                if (updCtl_q[`CFDU_BIT_ERASE_EN] && ptrNv_q) begin
                                    erasePage_q <= nvAddr[9:5];
                                    eraseIdx_q  <= 5'h00;
                                    timer_q     <= 24'h000000;
                                    state_q     <= ST_ERASE;
                                end
                            end else begin
                                ptr_q   <= busByte;
                                ptrNv_q <= (busByte >= `CFDU_NV_HI_FIRST) &&
                                           (busByte <= `CFDU_NV_HI_LAST);
                            end
                        end else if (ptrNv_q) begin
                            if (byteCnt_q == 2'h1) begin
                                ptrLo_q <= busByte;
                            end else begin
                                // Programming only clears bits; blank is ones.
                                nvMem[nvAddr] <= nvMem[nvAddr] & busByte;
                            end
                        end else if (ptr_q == `CFDU_ADDR_UPDATE) begin
                            updCtl_q <= busByte;
                        end else if (ptr_q == `CFDU_ADDR_DOWNLOAD) begin
                            dnCtl_q <= busByte;
                        end else if (ptr_q <= `CFDU_RAM_TOP) begin
                            latchA[ptr_q] <= busByte;
                            if (updCtl_q[`CFDU_BIT_OPEN]) begin
                                latchB[ptr_q] <= busByte;
                            end
                        end
                    end
                end
                default: begin
                    state_q <= ST_WAIT;
                end
            endcase
        end
    end
endmodule // cfdu_config_ctrl

// File: logic/cfdu_sync2.v
/*
 Two-flop synchroniser for one level from outside the clock domain.
 Assumes mclk and the asynchronous active-low reset of the main block.
*/
`timescale 1ns/100ps
module cfdu_sync2 (
    // Clock and reset.
    input  wire mclk,
    input  wire reset_n,
    input  wire clkEn,
    // Level in and out.
    input  wire asyncIn,
    output wire syncOut
);
    reg meta_q;
    reg stable_q;
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q   <= 1'b0;
            stable_q <= 1'b0;
        end else if (clkEn) begin
            meta_q   <= asyncIn;
            stable_q <= meta_q;
        end
    end
    assign syncOut = stable_q;
endmodule // cfdu_sync2

// File: shared/cfdu_defines.vh
/*
 Constants for the configuration download and update controller.
 Assumes inclusion by bare name from the logic files; definitions only.
*/
// Operation
// - Updates fill first stage, then second stage.
// - Above lockout, copy nonvolatile into first stage.
// - Then transfer all first to second together.
// - 0.5 ms later, load first state.
// - No acknowledge until power-up download done.
// - Update bit 0 set: both stages transparent.
// - Bit 0 clear: writes reach first stage only.
// - Bit 1 write pulses global stage transfer.
// - Erase ignored unless enabled; erase writes ones.
// - Nonvolatile edits leave running configuration alone.
// - Download bit copies pages 0-6 into RAM.
// - State memory: 63 states of 64 bits.
// - Met conditions fetch next state, ten microseconds.
// - First write byte loads the address pointer.
// - Nonvolatile cells at 0xF800 to 0xFBFF.
// - Thirty-two 32-byte pages; 0-6 mirror RAM.
// - Slave address 01101 plus two pins.
// - Identification registers at 0xF4 to 0xF7.
// - Erase enable is bit 2 at 0x90.
// - Command 0xFE erases page, busy 20 ms.
`ifndef CFDU_DEFINES_VH
`define CFDU_DEFINES_VH
`define CFDU_ADDR_UPDATE     8'h90
`define CFDU_ADDR_DOWNLOAD   8'hD8
`define CFDU_ADDR_MAKER      8'hF4
`define CFDU_ADDR_REVISION   8'hF5
`define CFDU_ADDR_BRAND0     8'hF6
`define CFDU_ADDR_BRAND1     8'hF7
`define CFDU_RAM_TOP         8'hDF
`define CFDU_NV_HI_FIRST     8'hF8
`define CFDU_NV_HI_LAST      8'hFB
`define CFDU_NV_CFG_HI       8'hF8
`define CFDU_CMD_ERASE       8'hFE
`define CFDU_BIT_OPEN        0
`define CFDU_BIT_XFER        1
`define CFDU_BIT_ERASE_EN    2
`define CFDU_BIT_DOWNLOAD    0
`define CFDU_SLAVE_UPPER     5'h0D
`define CFDU_CFG_PAGES       7
`define CFDU_PAGE_BYTES      32
`define CFDU_CFG_BYTES       224
`define CFDU_STATE_SLOTS     64
`define CFDU_CLK_HZ          10000000
`define CFDU_STATE_DELAY_US  500
`define CFDU_STATE_DELAY_CYC ((`CFDU_STATE_DELAY_US * (`CFDU_CLK_HZ / 1000000) + 0) )
`define CFDU_FETCH_US        10
`define CFDU_FETCH_CYC       (`CFDU_FETCH_US * (`CFDU_CLK_HZ / 1000000))
`define CFDU_ERASE_MS        20
`define CFDU_ERASE_CYC       (`CFDU_ERASE_MS * (`CFDU_CLK_HZ / 1000))
`endif

// File: verif/cfdu_bus_master.sv
/* Serial master model: frames byte transfers and runs the link clock.
   Assumes its tasks are entered 1 ns after a rising edge of mclk. */
`timescale 1ns/100ps
module cfdu_bus_master (
    // Clock and device answer.
    input  logic       mclk,
    input  logic       busAck,
    // Frame signals toward the device.
    output logic       linkClk,
    output logic       busStart,
    output logic       busRead,
    output logic       busByteValid,
    output logic       busStop,
    output logic       rdStrobe,
    output logic [6:0] busAddr,
    output logic [7:0] busByte
);
    logic inFrame = 1'b0;
    int   gap     = 0;
    ////////////////////////////////////////////////
    initial begin
        {busStart, busRead, busByteValid, busStop, rdStrobe} = 5'h00;
        busAddr = 7'h00;
        busByte = 8'h00;
        linkClk = 1'b1;
        #37;
        // The clock idles high between frames, where the pull-up leaves it.
        forever #400 linkClk = inFrame ? ~linkClk : 1'b1;
    end
    task automatic start(input logic [6:0] a, input logic rd, output logic ack);
        inFrame  = 1'b1;
        busStart = 1'b1;
        busAddr  = a;
        busRead  = rd;
        @(posedge mclk) #1;
        busStart = 1'b0;
        busAddr  = ~a;
        @(posedge mclk) ack = busAck;
        #1;
    endtask
    // Released data lines show the inverse so no stale byte looks valid.
    task automatic send(input logic [7:0] b);
        busByteValid = 1'b1;
        busByte      = b;
        @(posedge mclk) #1;
        busByteValid = 1'b0;
        busByte      = ~b;
        @(posedge mclk) #1;
        repeat (gap) @(posedge mclk) #1;
    endtask
    task automatic fetch();
        rdStrobe = 1'b1;
        @(posedge mclk) #1;
        rdStrobe = 1'b0;
        @(posedge mclk) #1;
    endtask
    task automatic stop();
        busStop = 1'b1;
        @(posedge mclk) #1;
        busStop = 1'b0;
        inFrame = 1'b0;
        @(posedge mclk) #1;
    endtask
endmodule // cfdu_bus_master

// File: verif/cfdu_config_ctrl_assertions.sv
/* Port checker for the configuration controller.
   Assumes clkEn is held high and binds onto every controller instance. */
`timescale 1ns/100ps
module cfdu_ctrl_checker #(
    parameter int         FETCH_CYC = 100,
    parameter logic [7:0] MAKER_ID  = 8'hA5,
    parameter logic [7:0] REVISION  = 8'h01,
    parameter logic [7:0] BRAND0    = 8'h5A,
    parameter logic [7:0] BRAND1    = 8'h3C
) (
    // Clock, reset and pins.
    input logic        mclk, reset_n, clkEn, supplyAboveLockout,
    input logic        addressPinHigh, addressPinLow, linkClk,
    // Serial slave front end.
    input logic        busStart, busRead, busByteValid, busStop, busAck,
    input logic [6:0]  busAddr,
    input logic [7:0]  busByte, busRdData,
    // Sequencing side and status.
    input logic        stateCondMet, stateBusy, downloadDone, linkEdge,
    input logic [63:0] stateWord,
    input logic [5:0]  stateIndex,
    input logic [6:0]  slaveAddr
);
    localparam int FETCH_LO = FETCH_CYC - 1;
    localparam int FETCH_HI = FETCH_CYC + 2;
    logic [7:0] ptrQ;
    logic       firstQ;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////
    // Shadow pointer; the erase command byte never moves it.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            firstQ <= 1'b0;
            ptrQ   <= 8'h00;
        end else if (busStart) begin
            firstQ <= !busRead;
        end else if (busByteValid && busAck) begin
            firstQ <= 1'b0;
            if (firstQ && busByte != 8'hFE) ptrQ <= busByte;
        end
    end
    ack_gate_a: assert property (!downloadDone |-> !busAck)
        else $error("acknowledge before download done");
    busy_refuse_a: assert property (stateBusy |-> !busAck)
        else $error("acknowledge during state load");
    nosel_ack_a: assert property (busStart && busAddr != slaveAddr |=> !busAck)
        else $error("acknowledge to a foreign address");
    stop_ack_a: assert property (busStop |=> !busAck)
        else $error("acknowledge after stop");
    slave_addr_a: assert property ((downloadDone && $stable({addressPinHigh, addressPinLow}))[*4]
        |-> slaveAddr == {5'h0D, addressPinHigh, addressPinLow}) else $error("slave address wrong");
    id_read_a: assert property (busAck && ptrQ[7:2] == 6'h3D |-> busRdData ==
        (ptrQ == 8'hF4 ? MAKER_ID : ptrQ == 8'hF5 ? REVISION : ptrQ == 8'hF6 ? BRAND0 : BRAND1))
        else $error("identification byte wrong");
    fetch_time_a: assert property ($rose(stateBusy) && $past(downloadDone)
        |-> ##[FETCH_LO:FETCH_HI] $changed(stateIndex)) else $error("state fetch time wrong");
    fetch_step_a: assert property ($changed(stateIndex) && $past(downloadDone) |-> stateIndex ==
        (($past(stateIndex) == 6'h3E) ? 6'h00 : $past(stateIndex) + 6'h01))
        else $error("state index step wrong");
    link_edge_a: assert property ($rose(linkClk) |-> ##[1:4] linkEdge)
        else $error("link edge missed");
    link_pulse_a: assert property (linkEdge |=> !linkEdge)
        else $error("link edge longer than one cycle");
    cover property ($rose(downloadDone));
    cover property ($rose(stateBusy) && downloadDone);
    cover property (busAck && ptrQ == 8'hF6);
endmodule // cfdu_ctrl_checker

bind cfdu_config_ctrl cfdu_ctrl_checker #(.FETCH_CYC(FETCH_CYC), .MAKER_ID(MAKER_ID),
    .REVISION(REVISION), .BRAND0(BRAND0), .BRAND1(BRAND1)) chk (.*);

// File: verif/cfdu_config_ctrl_tb.sv
/* Bench for the configuration controller with master model and scoreboard.
   Assumes shared/ is on the include path and clkEn stays high. */
`timescale 1ns/100ps
module cfdu_config_ctrl_tb;
    localparam logic [7:0] IDS [4] = '{8'h6B, 8'h02, 8'h11, 8'h7C}; // Arbitrary values.
    logic        mclk = 1'b0, reset_n = 1'b0, supplyAboveLockout = 1'b0, stateCondMet = 1'b0;
    logic        addressPinHigh, addressPinLow, linkClk, busStart, busRead, busByteValid;
    logic        busStop, busAck, stateBusy, downloadDone, linkEdge, rdStrobe, ack;
    logic [6:0]  busAddr, slaveAddr, devAddr;
    logic [7:0]  busByte, busRdData, r, r2;
    logic [63:0] stateWord;
    logic [5:0]  stateIndex;
    logic [7:0]  expQ [$];
    int          nErrors = 0, nChecks = 0, cyc = 0, n;
    integer      seed = 32'h4d210fd8;
    cfdu_config_ctrl #(.STATE_DELAY_CYC(20), .ERASE_CYC(50), .FETCH_CYC(4), .MAKER_ID(IDS[0]),
        .REVISION(IDS[1]), .BRAND0(IDS[2]), .BRAND1(IDS[3])) dut (.clkEn(1'b1), .*);
    cfdu_bus_master m (.*);
    ////////////////////////////////////////////////
    initial forever #50 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            nErrors++;
            endOfTest();
        end
    end
    always @(posedge mclk) if (rdStrobe === 1'b1) chk8(busRdData, expQ.pop_front());
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        nChecks++;
        if (got !== exp) begin
            nErrors++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask
    task automatic wr(input int cnt, input logic [7:0] b0, b1 = 8'h00, b2 = 8'h00);
        m.start(devAddr, 1'b0, ack);
        m.send(b0);
        if (cnt > 1) m.send(b1);
        if (cnt > 2) m.send(b2);
        m.stop();
    endtask
    task automatic rd(input logic [7:0] exp);
        m.start(devAddr, 1'b1, ack);
        expQ.push_back(exp);
        m.fetch();
        m.stop();
    endtask
    task automatic probe(input logic exp);
        m.start(devAddr, 1'b0, ack);
        m.stop();
        chk1(ack, exp);
    endtask
    // Polling is bounded so a device that never frees the bus fails the check instead of hanging the run.
    task automatic waitReady();
        n = 0;
        do begin
            m.start(devAddr, 1'b0, ack);
            m.stop();
            n++;
        end while (ack !== 1'b1 && n < 200);
        chk1(ack, 1'b1);
    endtask
    task automatic endOfTest();
        if (nErrors == 0 && nChecks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        {addressPinHigh, addressPinLow} = 2'($random(seed));
        devAddr = {5'h0D, addressPinHigh, addressPinLow};
        repeat (6) @(posedge mclk);
        #1 reset_n = 1'b1;
        repeat (10) @(posedge mclk) #1;
        chk1(downloadDone, 1'b0);
        probe(1'b0);
        supplyAboveLockout = 1'b1;
        n = 0;
        while (downloadDone !== 1'b1 && n < 400) begin
            @(posedge mclk) #1;
            n++;
        end
        chk1(n >= 245 && n <= 260, 1'b1);
        chk8({1'b0, slaveAddr}, {1'b0, devAddr});
        for (int k = 1; k < 3; k++) begin
            stateCondMet = 1'b1;
            @(posedge mclk) #1;
            stateCondMet = 1'b0;
            chk1(stateBusy, 1'b1);
            repeat (12) @(posedge mclk) #1;
            chk8({2'b00, stateIndex}, 8'(k));
        end
        m.start(devAddr ^ 7'h01, 1'b0, ack);
        m.stop();
        chk1(ack, 1'b0);
        m.gap = 2;
        for (int i = 0; i < 4; i++) begin
            wr(2, 8'(8'hF4 + i), 8'h00);
            rd(IDS[i]);
        end
        wr(2, 8'h90, 8'h06);
        wr(1, 8'h90);
        rd(8'h04);
        r = 8'($random(seed));
        wr(2, 8'h05, r);
        wr(1, 8'h05);
        rd(r);
        for (int p = 0; p < 7; p += 2) begin
            wr(2, 8'hF8, 8'(p * 32));
            wr(1, 8'hFE);
            if (p == 0) probe(1'b0);
            waitReady();
        end
        wr(2, 8'hFA, 8'h18);
        wr(1, 8'hFE);
        waitReady();
        wr(3, 8'hFA, 8'h18, r);
        stateCondMet = 1'b1;
        @(posedge mclk) #1;
        stateCondMet = 1'b0;
        repeat (12) @(posedge mclk) #1;
        chk8({2'b00, stateIndex}, 8'h03);
        chk8(stateWord[7:0], r);
        chk8(stateWord[63:56], 8'hFF);
        wr(2, 8'hF8, 8'h05);
        rd(8'hFF);
        r2 = 8'($random(seed));
        wr(3, 8'hF8, 8'h05, r2);
        wr(3, 8'hF8, 8'h90, 8'h00);
        wr(3, 8'hF8, 8'hD8, 8'h00);
        wr(2, 8'hF8, 8'h05);
        rd(r2);
        wr(1, 8'h05);
        rd(r);
        wr(2, 8'h90, 8'h00);
        wr(2, 8'hF8, 8'h00);
        wr(1, 8'hFE);
        probe(1'b1);
        wr(2, 8'hF8, 8'h05);
        rd(r2);
        wr(2, 8'hD8, 8'h01);
        waitReady();
        wr(1, 8'h05);
        rd(r2);
        wr(1, 8'hD8);
        rd(8'h00);
        repeat (4) @(posedge mclk) #1;
        endOfTest();
    end
endmodule // cfdu_config_ctrl_tb
